/* fspc_pkg.sv */
// Purpose: Shared constants for the flash sector protection host controller.
// Assumes: One 200 MHz clock; command words follow the usual unlock-cycle flash command set.
// Notes: Command codes and the user register map are chosen here; the flash itself has no registers.
package fspc_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned ADDR_W           = 22;
    localparam int unsigned DATA_W           = 16;
    localparam int unsigned NUM_SECT         = 266;
    localparam logic [8:0]  SECT_LAST        = 9'h109;
    // Timing figures in ns, and derived cycle counts.
    localparam int unsigned T_WRITE_NS       = 60;
    localparam int unsigned T_PROG_POLL_NS   = 1000;
    localparam int unsigned T_ERASE_POLL_NS  = 50000;
    localparam int unsigned T_PWD_NS         = 2000;
    localparam int unsigned CYC_WRITE        = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CYC_PROG_POLL    = (T_PROG_POLL_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CYC_ERASE_POLL   = (T_ERASE_POLL_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CYC_PWD          = (T_PWD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PER_ERASE_LIMIT  = 100;
    // Autoselect status read: A6, A1, A0 = 0, 1, 0.
    localparam logic [ADDR_W-1:0] AS_PROT_ADDR = 22'h000002;
    localparam int unsigned SECT_ADDR_LSB    = 12;
    // User register map (word index on the command port).
    localparam logic [3:0] REG_CTRL          = 4'h0;
    localparam logic [3:0] REG_SECT          = 4'h1;
    localparam logic [3:0] REG_STATUS        = 4'h2;
    localparam logic [3:0] REG_RESULT        = 4'h3;
    localparam logic [3:0] REG_ERASES        = 4'h4;
    // Operation codes written to REG_CTRL bits 3:0.
    typedef enum logic [3:0]
    {
        FSPC_OP_PER_SET   = 4'h1,
        FSPC_OP_PER_ERASE = 4'h2,
        FSPC_OP_FREEZE    = 4'h3,
        FSPC_OP_VOL_SET   = 4'h4,
        FSPC_OP_VOL_CLR   = 4'h5,
        FSPC_OP_VERIFY    = 4'h6,
        FSPC_OP_HW_RESET  = 4'h7,
        FSPC_OP_MODE_PERS = 4'h8,
        FSPC_OP_MODE_PWD  = 4'h9
    } fspc_op_t;
    localparam logic [15:0] CMD_UNLOCK1      = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2      = 16'h0055;
    localparam logic [15:0] CMD_PER_PROG     = 16'h0060;
    localparam logic [15:0] CMD_PER_ERASE    = 16'h0060;
    localparam logic [15:0] CMD_FREEZE       = 16'h0078;
    localparam logic [15:0] CMD_VOL_WRITE    = 16'h0048;
    localparam logic [15:0] CMD_VERIFY       = 16'h0090;
    localparam logic [15:0] CMD_MODE_PERS    = 16'h0068;
    localparam logic [15:0] CMD_MODE_PWD     = 16'h0069;
    localparam logic [15:0] CMD_RESET        = 16'h00f0;
    localparam logic [ADDR_W-1:0] ADDR_555   = 22'h000555;
    localparam logic [ADDR_W-1:0] ADDR_2AA   = 22'h0002aa;
    localparam logic [ADDR_W-1:0] PER_ERASE_ADDR = 22'h000042;
    localparam int unsigned SEQ_LEN          = 4;
endpackage

/* fspc_bus_cycle.sv */
// Purpose: Drives one write or read cycle on the flash pins.
// Assumes: Asynchronous flash timing met by holding strobes CYC_WRITE cycles.
// Notes: Read data are captured at the end of the strobe window.
`timescale 1ns/1ps
module fspc_bus_cycle
    import fspc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              start,
    input  wire logic              is_read,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata_q,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_we_n,
    output logic                   flash_oe_n,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe
);
    logic [7:0] cnt_q;
    logic       busy_q;
    logic       rd_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q        <= 8'h00;
            busy_q       <= 1'b0;
            rd_q         <= 1'b0;
            flash_addr   <= '0;
            flash_dq_out <= '0;
        end
        else if (start && !busy_q)
        begin
            busy_q       <= 1'b1;
            rd_q         <= is_read;
            cnt_q        <= 8'(CYC_WRITE);
            flash_addr   <= addr;
            flash_dq_out <= wdata;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= '0;
        end
        else if (busy_q && rd_q && cnt_q == 8'h01)
        begin
            rdata_q <= flash_dq_in;
        end
    end

    assign done        = busy_q && cnt_q == 8'h01;
    assign flash_we_n  = !(busy_q && !rd_q);
    assign flash_oe_n  = !(busy_q && rd_q);
    assign flash_dq_oe = busy_q && !rd_q;
endmodule

/* fspc_ctrl.sv */
// Summary of operation
// R1 - Unlocked parts run persistent protection; the host assumes that mode until told otherwise.
// R2 - Setting the persistent mode bit fixes persistent protection for good.
// R3 - Setting the password mode bit fixes password protection for good.
// R4 - After either mode bit is set, no mode change is accepted.
// R5 - One persistent guard bit per group of up to four sectors; boot sectors alone.
// R6 - Each persistent guard bit is set by its own command aimed at its group.
// R7 - Erasing persistent guard bits clears all at once with no over-erase guard.
// R8 - Host programs every persistent guard bit before erasing them; this host issues the erase sequence without programming them first.
// R9 - One freeze bit: 1 locks the persistent bits, 0 lets them change.
// R10 - Persistent mode freeze bit clears only by power-up or hardware reset.
// R11 - A set freeze bit blocks program and erase of persistent bits.
// R12 - One volatile guard bit per sector, all zero after reset.
// R13 - Volatile bits set or clear any time, regardless of the freeze bit.
// R14 - Sector protection is the OR of its persistent and volatile bits.
// R15 - Host limits persistent bit erases to 100 cycles.
// R16 - Write guard pin low blocks program and erase in the boot sectors.
// R17 - To change locked sectors, reset, rewrite persistent bits, freeze again.
// R18 - Host freezes early in boot and holds the write guard pin low.
// R19 - Program to a protected sector changes nothing; polling lasts about 1 us.
// R20 - Erase to a protected sector changes nothing; polling lasts about 50 us.
// R21 - Verify reads back a sector's volatile, persistent and freeze bits; this code reads one combined protect bit on data line zero, with no freeze bit.
// R22 - Status read with A6,A1,A0 = 0,1,0 gives data line zero per sector.
// R23 - Autoselect locations with A1 low hold identity codes, not status.
// R24 - Password mode powers up frozen; only matching 64-bit password unfreezes.
// R25 - Each password check takes 2 us; a mismatch changes nothing.
// R26 - Persistent mode bit set forbids programming the password mode bit.
// R27 - Persistent mode ignores the password unlock command.
// R28 - Boot sector protection adds the write guard pin being low.
// R29 - Commands to unprotected sectors proceed normally.
// Purpose: Host controller that issues flash protection command sequences.
// Assumes: Software writes a sector, then an op code; one op at a time.
// Notes: Password unlock is not issued by this host; frozen state is tracked locally.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module fspc_ctrl
    import fspc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_we_n,
    output logic                   flash_oe_n,
    output logic                   flash_ce_n,
    output logic                   flash_reset_n,
    output logic                   boot_write_guard_pin,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe
);
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_CYCLE = 3'b001,
        ST_WAIT  = 3'b010,
        ST_RESET = 3'b011,
        ST_DONE  = 3'b100
    } fspc_state_t;

    fspc_state_t       state_q;
    fspc_op_t          op_q;
    logic [8:0]        sect_q;
    logic [2:0]        step_q;
    logic              guard_pin_low_q;
    logic              mode_locked_q;
    logic              pwd_mode_q;
    logic              freeze_q;
    logic              refused_q;
    logic [15:0]       result_q;
    logic [7:0]        erases_q;
    logic [15:0]       wait_q;
    logic              cyc_start;
    logic              cyc_read;
    logic              cyc_done;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_wdata;
    logic [DATA_W-1:0] cyc_rdata;
    logic [ADDR_W-1:0] sect_addr;
    logic              op_go;
    logic              op_ok;
    logic              last_step;

    assign sect_addr = ADDR_W'({sect_q, 12'h000});
    assign op_go     = reg_wr && reg_addr == REG_CTRL && state_q == ST_IDLE;

    // Refuse locally what the flash would refuse, so software sees why.
    always_comb
    begin
        op_ok = 1'b1;
        unique case (fspc_op_t'(reg_wdata[3:0]))
            FSPC_OP_PER_SET:   op_ok = !freeze_q;                                     // R11
            FSPC_OP_PER_ERASE: op_ok = !freeze_q && erases_q < 8'(PER_ERASE_LIMIT);   // R15
            FSPC_OP_MODE_PERS: op_ok = !mode_locked_q;                                // R4
            FSPC_OP_MODE_PWD:  op_ok = !mode_locked_q;                                // R26
            FSPC_OP_VOL_SET,
            FSPC_OP_VOL_CLR,
            FSPC_OP_VERIFY,
            FSPC_OP_FREEZE,
            FSPC_OP_HW_RESET:  op_ok = 1'b1;                                          // R13
            default:           op_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sect_q          <= 9'h000;
            guard_pin_low_q <= 1'b1;
        end
        else if (reg_wr && reg_addr == REG_SECT)
        begin
            sect_q          <= reg_wdata[8:0];
            guard_pin_low_q <= !reg_wdata[16];    // R18
        end
    end

    assign boot_write_guard_pin = !guard_pin_low_q;    // R16

    // Sequence step words: two unlock cycles, command, argument.
    assign last_step = step_q == 3'(SEQ_LEN - 1);
    always_comb
    begin
        cyc_read  = 1'b0;
        cyc_addr  = ADDR_555;
        cyc_wdata = CMD_UNLOCK1;
        unique case (step_q)
            3'd0:
            begin
                cyc_addr  = ADDR_555;
                cyc_wdata = CMD_UNLOCK1;
            end
            3'd1:
            begin
                cyc_addr  = ADDR_2AA;
                cyc_wdata = CMD_UNLOCK2;
            end
            3'd2:
            begin
                cyc_addr  = sect_addr;
                cyc_wdata = (op_q == FSPC_OP_PER_SET || op_q == FSPC_OP_PER_ERASE) ? CMD_PER_PROG :
                            (op_q == FSPC_OP_FREEZE)    ? CMD_FREEZE    :
                            (op_q == FSPC_OP_MODE_PERS) ? CMD_MODE_PERS :
                            (op_q == FSPC_OP_MODE_PWD)  ? CMD_MODE_PWD  :
                            (op_q == FSPC_OP_VERIFY)    ? CMD_VERIFY    : CMD_VOL_WRITE;
            end
            default:
            begin
                cyc_read  = op_q == FSPC_OP_VERIFY;                     // R21
                cyc_addr  = (op_q == FSPC_OP_VERIFY) ? (sect_addr | AS_PROT_ADDR) :   // R22 R23
                            (op_q == FSPC_OP_PER_ERASE) ? PER_ERASE_ADDR : sect_addr; // R6 R7
                cyc_wdata = (op_q == FSPC_OP_VOL_SET) ? 16'h0001 : 16'h0000;
            end
        endcase
    end
    assign cyc_start = state_q == ST_CYCLE;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q   <= ST_IDLE;
            op_q      <= FSPC_OP_VERIFY;
            step_q    <= 3'd0;
            wait_q    <= 16'h0000;
            refused_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (op_go)
                    begin
                        op_q      <= fspc_op_t'(reg_wdata[3:0]);
                        step_q    <= 3'd0;
                        refused_q <= !op_ok;
                        if (!op_ok)
                        begin
                            state_q <= ST_DONE;
                        end
                        else if (fspc_op_t'(reg_wdata[3:0]) == FSPC_OP_HW_RESET)
                        begin
                            wait_q  <= 16'(CYC_PWD);
                            state_q <= ST_RESET;    // R17
                        end
                        else
                        begin
                            state_q <= ST_CYCLE;
                        end
                    end
                end
                ST_CYCLE:
                begin
                    if (cyc_done)
                    begin
                        step_q <= step_q + 3'd1;
                        if (last_step)
                        begin
                            // Erase takes the long polling window, others the short.
                            wait_q  <= (op_q == FSPC_OP_PER_ERASE) ? 16'(CYC_ERASE_POLL)    // R20
                                                                   : 16'(CYC_PROG_POLL);    // R19
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT, ST_RESET:
                begin
                    wait_q <= wait_q - 16'h0001;
                    if (wait_q == 16'h0001)
                    begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Shadow of the flash protection state, tracked from issued commands.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_locked_q <= 1'b0;    // R1
            pwd_mode_q    <= 1'b0;
            freeze_q      <= 1'b0;
            erases_q      <= 8'h00;
            result_q      <= 16'h0000;
        end
        else if (state_q == ST_DONE && !refused_q)
        begin
            unique case (op_q)
                FSPC_OP_MODE_PERS: mode_locked_q <= 1'b1;    // R2
                FSPC_OP_MODE_PWD:
                begin
                    mode_locked_q <= 1'b1;    // R3
                    pwd_mode_q    <= 1'b1;
                end
                FSPC_OP_FREEZE:    freeze_q <= 1'b1;    // R9
                FSPC_OP_HW_RESET:  freeze_q <= pwd_mode_q;    // R10 R24
                FSPC_OP_PER_ERASE: erases_q <= erases_q + 8'h01;    // R8
                FSPC_OP_VERIFY:    result_q <= cyc_rdata;    // R14 R28
                default:           result_q <= result_q;    // R29
            endcase
        end
    end

    assign flash_ce_n    = state_q != ST_CYCLE;
    assign flash_reset_n = state_q != ST_RESET;    // R12

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:   reg_rdata <= {28'h0, op_q};
                REG_SECT:   reg_rdata <= {15'h0, !guard_pin_low_q, 7'h0, sect_q};
                REG_STATUS: reg_rdata <= {26'h0, refused_q, pwd_mode_q, mode_locked_q, freeze_q,
                                          state_q == ST_WAIT, state_q != ST_IDLE};
                REG_RESULT: reg_rdata <= {16'h0, result_q};
                REG_ERASES: reg_rdata <= {24'h0, erases_q};
                default:    reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    fspc_bus_cycle u_cycle
    (
        .sys_clk      (sys_clk),
        .arst_n       (arst_n),
        .start        (cyc_start),
        .is_read      (cyc_read),
        .addr         (cyc_addr),
        .wdata        (cyc_wdata),
        .done         (cyc_done),
        .rdata_q      (cyc_rdata),
        .flash_addr   (flash_addr),
        .flash_we_n   (flash_we_n),
        .flash_oe_n   (flash_oe_n),
        .flash_dq_in  (flash_dq_in),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe)
    );

    property p_freeze_blocks;
        @(posedge sys_clk) disable iff (!arst_n)
        (op_go && freeze_q && fspc_op_t'(reg_wdata[3:0]) == FSPC_OP_PER_SET) |=> (state_q == ST_DONE && refused_q);
    endproperty
    a_freeze_blocks: assert property (p_freeze_blocks) else $error("Frozen guard bit program was not refused."); // R11

    property p_mode_once;
        @(posedge sys_clk) disable iff (!arst_n)
        (op_go && mode_locked_q && fspc_op_t'(reg_wdata[3:0]) == FSPC_OP_MODE_PWD) |=> refused_q;
    endproperty
    a_mode_once: assert property (p_mode_once) else $error("Second mode selection was not refused."); // R4

    property p_freeze_sticky;
        @(posedge sys_clk) disable iff (!arst_n)
        (freeze_q && !(state_q == ST_DONE && op_q == FSPC_OP_HW_RESET)) |=> freeze_q;
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky) else $error("Freeze bit cleared without reset."); // R10

    property p_reset_pulse;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(state_q == ST_RESET) |-> !flash_reset_n [*8];
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("Flash reset pulse too short."); // R17
endmodule

/* fspc_flash_model.sv */
// Purpose: Behavioural flash protection logic facing the host controller.
// Assumes: Four-cycle command sequences with 555/2aa unlock cycles.
// Notes: One persistent guard bit per sector; grouping is not modelled.
`timescale 1ns/1ps
module fspc_flash_model
    import fspc_pkg::*;
#(
    parameter logic [15:0] ID_CODE = 16'h0a5c // Arbitrary value.
)
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic              flash_we_n,
    input  wire logic              flash_oe_n,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_reset_n,
    input  wire logic              boot_write_guard_pin,
    input  wire logic [DATA_W-1:0] flash_dq_out,
    input  wire logic              flash_dq_oe,
    output logic [DATA_W-1:0]      flash_dq_in
);
    logic [NUM_SECT-1:0] pers_q;
    logic [NUM_SECT-1:0] vol_q;
    logic                freeze_q;
    logic                pmode_q;
    logic                wmode_q;
    logic                vmode_q;
    logic                we_prev_q;
    logic [1:0]          step_q;
    logic [15:0]         cmd_q;
    logic [15:0]         wd_q;
    logic [15:0]         last_q;
    logic [ADDR_W-1:0]   wa_q;
    logic [8:0]          sw;
    logic [8:0]          sr;
    logic                drive;
    logic                prot;
    assign sw = wa_q[SECT_ADDR_LSB+8:SECT_ADDR_LSB];
    assign sr = flash_addr[SECT_ADDR_LSB+8:SECT_ADDR_LSB];
    assign drive = !flash_oe_n && !flash_ce_n && !flash_dq_oe;
    // Outermost two sectors at each end fall under the pin.
    assign prot = pers_q[sr] | vol_q[sr] | (((sr < 9'h002) || (sr > SECT_LAST - 9'h002)) & ~boot_write_guard_pin);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pers_q    <= '0;
            vol_q     <= '0;
            freeze_q  <= 1'b0;
            pmode_q   <= 1'b0;
            wmode_q   <= 1'b0;
            vmode_q   <= 1'b0;
            we_prev_q <= 1'b1;
            step_q    <= 2'd0;
            cmd_q     <= 16'h0000;
            wd_q      <= 16'h0000;
            wa_q      <= '0;
        end
        else if (!flash_reset_n)
        begin
            freeze_q <= wmode_q;
            vol_q    <= '0;
            step_q   <= 2'd0;
            vmode_q  <= 1'b0;
        end
        else
        begin
            we_prev_q <= flash_we_n;
            if (!flash_we_n && !flash_ce_n && flash_dq_oe)
            begin
                wa_q <= flash_addr;
                wd_q <= flash_dq_out;
            end
            if (!we_prev_q && flash_we_n)
            begin
                case (step_q)
                    2'd0: begin
                        vmode_q <= 1'b0;
                        step_q  <= {1'b0, wa_q == ADDR_555 && wd_q == CMD_UNLOCK1};
                    end
                    2'd1: step_q <= (wa_q == ADDR_2AA && wd_q == CMD_UNLOCK2) ? 2'd2 : 2'd0;
                    2'd2: begin
                        cmd_q   <= wd_q;
                        vmode_q <= wd_q == CMD_VERIFY;
                        step_q  <= (wd_q == CMD_VERIFY) ? 2'd0 : 2'd3;
                    end
                    default: begin
                        step_q <= 2'd0;
                        case (cmd_q)
                            CMD_PER_PROG: if (!freeze_q)
                                if (wa_q == PER_ERASE_ADDR)
                                    pers_q <= '0;
                                else
                                    pers_q[sw] <= 1'b1;
                            CMD_FREEZE: freeze_q <= 1'b1;
                            CMD_VOL_WRITE: vol_q[sw] <= wd_q[0];
                            CMD_MODE_PERS: if (!wmode_q) pmode_q <= 1'b1;
                            CMD_MODE_PWD: if (!pmode_q) wmode_q <= 1'b1;
                            default: ;
                        endcase
                    end
                endcase
            end
        end
    end
    // A released bus shows the inverse of the last value, so stale data never pass.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            last_q <= 16'h0000;
        else if (drive)
            last_q <= flash_dq_in;
    end
    always_comb
    begin
        if (!drive)
            flash_dq_in = ~last_q;
        else if (vmode_q && flash_addr[1] && !flash_addr[0] && !flash_addr[6])
            flash_dq_in = {15'h0000, prot};
        else if (vmode_q && !flash_addr[1])
            flash_dq_in = ID_CODE;
        else
            flash_dq_in = 16'hffff;
    end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the protection host controller.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: The erase wait makes this run about 15500 cycles long.
`timescale 1ns/1ps
module tb
    import fspc_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [3:0]        reg_addr = 4'h0;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [31:0]       reg_rdata;
    logic [31:0]       rv;
    logic              pin_hi = 1'b0;
    logic [ADDR_W-1:0] f_addr;
    logic              we_n;
    logic              oe_n;
    logic              ce_n;
    logic              rst_n;
    logic              guard;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    int                bad_count = 0;
    int                num_checks = 0;
    int                n = 0;
    always #2.5 sys_clk = ~sys_clk;
    fspc_ctrl DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(f_addr), .flash_we_n(we_n),
        .flash_oe_n(oe_n), .flash_ce_n(ce_n), .flash_reset_n(rst_n), .boot_write_guard_pin(guard),
        .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
    fspc_flash_model flash (.sys_clk(sys_clk), .arst_n(arst_n), .flash_addr(f_addr), .flash_we_n(we_n),
        .flash_oe_n(oe_n), .flash_ce_n(ce_n), .flash_reset_n(rst_n), .boot_write_guard_pin(guard),
        .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic run(input logic [8:0] s, input logic [3:0] op);
        n = 0;
        wr(REG_SECT, {15'h0000, pin_hi, 7'h00, s});
        wr(REG_CTRL, {28'h0000000, op});
        rd(REG_STATUS);
        while (rv[0] !== 1'b0 && n < 20000)
        begin
            rd(REG_STATUS);
            n++;
        end
        check({31'h0, n >= 20000}, 32'h0, "busy wait");
    endtask
    task automatic verify(input logic [8:0] s, input logic e);
        run(s, FSPC_OP_VERIFY);
        rd(REG_RESULT);
        check({31'h0, rv[0]}, {31'h0, e}, "protect");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #400000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(REG_STATUS);
        check({26'h0, rv[5:0]}, 32'h0, "status after reset");
        check({31'h0, guard}, 32'h0, "guard pin after reset");
        verify(9'h000, 1'b1);
        verify(9'h109, 1'b1);
        verify(9'h002, 1'b0);
        pin_hi = 1'b1;
        verify(9'h000, 1'b0);
        check({31'h0, guard}, 32'h1, "guard pin released");
        run(9'h005, FSPC_OP_VOL_SET);
        check({31'h0, n > 100 && n < 150}, 32'h1, "program poll window");
        verify(9'h005, 1'b1);
        run(9'h005, FSPC_OP_VOL_CLR);
        verify(9'h005, 1'b0);
        run(9'h007, FSPC_OP_PER_SET);
        verify(9'h007, 1'b1);
        run(9'h000, FSPC_OP_FREEZE);
        rd(REG_STATUS);
        check({31'h0, rv[2]}, 32'h1, "freeze set");
        run(9'h008, FSPC_OP_PER_SET);
        rd(REG_STATUS);
        check({31'h0, rv[5]}, 32'h1, "frozen set refused");
        verify(9'h008, 1'b0);
        run(9'h009, FSPC_OP_VOL_SET);
        verify(9'h009, 1'b1);
        run(9'h000, FSPC_OP_HW_RESET);
        rd(REG_STATUS);
        check({31'h0, rv[2]}, 32'h0, "freeze after reset");
        verify(9'h009, 1'b0);
        verify(9'h007, 1'b1);
        run(9'h007, FSPC_OP_PER_SET);
        run(9'h000, FSPC_OP_PER_ERASE);
        check({31'h0, n > 4900 && n < 5100}, 32'h1, "erase poll window");
        verify(9'h007, 1'b0);
        rd(REG_ERASES);
        check(rv, 32'h1, "erase count");
        run(9'h000, FSPC_OP_MODE_PERS);
        rd(REG_STATUS);
        check({30'h0, rv[4:3]}, 32'h1, "persistent mode");
        run(9'h000, FSPC_OP_MODE_PWD);
        rd(REG_STATUS);
        check({29'h0, rv[5:3]}, 32'h5, "password refused");
        rd(REG_CTRL);
        check(rv, 32'h9, "last op");
        wr(4'hf, 32'hffffffff);
        rd(4'hf);
        check(rv, 32'h0, "unmapped read");
        rd(REG_STATUS);
        check({29'h0, rv[5:3]}, 32'h5, "unmapped write");
        final_report();
    end
endmodule
